// ### design/fcs_top.sv
// What this block does
// - Each command opens with one array write; address and data are latched.
// - Command codes accepted: 0x05, 0x20, 0x25, 0x40, 0x41, held in buffer.
// - Writing one to buffer-empty flag clears it and launches the command.
// - Writing zero to buffer-empty mid-sequence cancels it and sets access error.
// - Command-complete flag reports when the launched command has finished.
// - Burst keeps pump on only if next burst queued and in same row.
// - A row is 64 bytes; address bits 5..0 zero start a new row.
// - First burst byte or new-row byte takes byte time; others take burst time.
// - No queued burst at completion: pump switched off.
// - Access error cleared by writing one; while set, commands are refused.
// - Array write before divider is configured sets access error.
// - Array write while command buffer is full sets access error.
// - Second array write or second command write before launch sets error.
// - After array write, writing any control register but command sets error.
// - Command code outside the five values sets access error.
// - After command write, any control access except launch sets error.
// - Stop mode during program or erase aborts it and sets access error.
// - Secured chip: debug path may only issue blank check or mass erase.
// - Protection loads from nonvolatile copy; only debug path may write it.
// - Last unprotected address is boundary bits then ones; disable bit low enables.
// - Partial protection and redirect enabled: vectors move below protected region.
// - Times: byte 9, burst 4, page erase 4000, mass erase 20000 flash cycles.
`timescale 1ns/1ps
module fcs_top
    import fcs_pkg::*;
#(
    parameter int PAGE_CYC = FCS_PAGE_CYC,
    parameter int MASS_CYC = FCS_MASS_CYC
)
(
    input wire logic mclk_i,
    input wire logic arst_n_i,
    input wire fcs_pkg::fcs_bus_t bus_i,
    output logic [7:0] bus_rdata_o,
    input wire logic stop_i,
    input wire logic [7:0] nv_protection_setting_i,
    input wire logic [7:0] nv_option_setting_i,
    input wire logic nvm_blank_i,
    output fcs_pkg::fcs_nvm_t nvm_o,
    input wire logic [15:0] vec_addr_i,
    output logic [15:0] vec_addr_o
);
    import fcs_pkg::*;

    // ----------------------------------------------------------------
    // Reset release
    // ----------------------------------------------------------------
    logic rst_meta_r, rst_n;

    always_ff @(posedge mclk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            rst_meta_r <= 1'b0;
            rst_n <= 1'b0;
        end
        else
        begin
            rst_meta_r <= 1'b1;
            rst_n <= rst_meta_r;
        end
    end

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    fcs_seq_t seq_r, seq_nxt;
    fcs_pend_t pend_r, pend_nxt;
    fcs_nvm_t nvm_nxt;
    logic [14:0] cnt_r, cnt_nxt;
    logic [7:0] clock_divider_r, clock_divider_nxt;
    logic [7:0] protection_reg_r, protection_reg_nxt;
    logic [7:0] option_r, option_nxt;
    logic nv_loaded_r, nv_loaded_nxt;
    logic ccf_r, ccf_nxt;
    logic accerr_r, accerr_nxt;
    logic pviol_r, pviol_nxt;
    logic blank_r, blank_nxt;
    logic [7:0] rdata_nxt;
    logic [15:0] vec_nxt;
    logic fclk_tick;

    fcs_fclk_div u_div (
        .clk_i(mclk_i),
        .rst_n_i(rst_n),
        .run_i(clock_divider_r[FCS_DIV_LOADED]),
        .pre8_i(clock_divider_r[FCS_DIV_PRE8]),
        .div_i(clock_divider_r[5:0]),
        .tick_o(fclk_tick)
    );

    // ----------------------------------------------------------------
    // Decoding helpers
    // ----------------------------------------------------------------
    function automatic logic is_ctrl(input logic [15:0] a);
        is_ctrl = (a >= FCS_ADDR_CLKDIV) && (a <= FCS_ADDR_CMD);
    endfunction

    function automatic logic [15:0] last_unprot(input logic [7:0] p);
        last_unprot = {p[7:1], {FCS_BOUND_LSB{1'b1}}};
    endfunction

    function automatic logic prot_hit(input logic [7:0] p, input logic [15:0] a);
        prot_hit = !p[FCS_PROT_DIS] && (a > last_unprot(p));
    endfunction

    function automatic logic code_ok(input logic [6:0] c);
        code_ok = (c == FCS_CMD_BLANK) || (c == FCS_CMD_BYTE) || (c == FCS_CMD_BURST)
            || (c == FCS_CMD_PAGE) || (c == FCS_CMD_MASS);
    endfunction

    function automatic logic [14:0] op_time(input logic [6:0] c);
        unique case (c)
            FCS_CMD_PAGE: op_time = PAGE_CYC[14:0];
            FCS_CMD_MASS: op_time = MASS_CYC[14:0];
            FCS_CMD_BLANK: op_time = FCS_BLANK_CYC;
            default: op_time = FCS_BYTE_CYC;
        endcase
    endfunction

    // ----------------------------------------------------------------
    // Sequencer, execution and register next values
    // ----------------------------------------------------------------
    logic arr_wr, ctrl_wr, ctrl_rd, secured, err, running, done, launch;
    logic burst_chain, start_q, refused;
    logic [15:0] next_addr, lu;

    always_comb
    begin
        seq_nxt = seq_r;
        pend_nxt = pend_r;
        nvm_nxt = nvm_o;
        cnt_nxt = cnt_r;
        clock_divider_nxt = clock_divider_r;
        protection_reg_nxt = protection_reg_r;
        option_nxt = option_r;
        nv_loaded_nxt = 1'b1;
        ccf_nxt = ccf_r;
        pviol_nxt = pviol_r;
        blank_nxt = blank_r;
        err = 1'b0;
        launch = 1'b0;
        start_q = 1'b0;
        arr_wr = bus_i.wr && (bus_i.addr >= FCS_FLASH_BASE);
        ctrl_wr = bus_i.wr && is_ctrl(bus_i.addr);
        ctrl_rd = bus_i.rd && is_ctrl(bus_i.addr);
        secured = (option_r[1:0] != FCS_SEC_OPEN);
        running = nvm_o.prog || nvm_o.erase || nvm_o.blank_chk;
        done = running && fclk_tick && (cnt_r == FCS_CNT_ONE);
        next_addr = nvm_o.addr + 16'h0001;
        lu = last_unprot(protection_reg_r);
        refused = 1'b0;

        // Nonvolatile copies are caught once, at the first edge after release
        if (!nv_loaded_r)
        begin
            protection_reg_nxt = nv_protection_setting_i;
            option_nxt = nv_option_setting_i;
        end

        // Flag clears and register writes outside a sequence
        if (ctrl_wr && (seq_r == FCS_SEQ_IDLE || seq_r == FCS_SEQ_QUEUED))
        begin
            if (bus_i.addr == FCS_ADDR_STATUS)
            begin
                if (bus_i.wdata[FCS_ST_PVIOL])
                    pviol_nxt = 1'b0;
            end
            if (bus_i.addr == FCS_ADDR_CLKDIV && !clock_divider_r[FCS_DIV_LOADED]
                && !accerr_r)
            begin
                clock_divider_nxt = {1'b1, bus_i.wdata[6:0]};
            end
            if (bus_i.addr == FCS_ADDR_PROT && bus_i.background_debug_path)
                protection_reg_nxt = bus_i.wdata;
        end

        unique case (seq_r)
            FCS_SEQ_IDLE:
            begin
                if (arr_wr && !accerr_r)
                begin
                    if (!clock_divider_r[FCS_DIV_LOADED])
                        err = 1'b1;
                    else
                    begin
                        pend_nxt.addr = bus_i.addr;
                        pend_nxt.data = bus_i.wdata;
                        seq_nxt = FCS_SEQ_LATCHED;
                    end
                end
            end
            FCS_SEQ_LATCHED:
            begin
                if (arr_wr)
                    err = 1'b1;
                else if (ctrl_wr && bus_i.addr == FCS_ADDR_CMD)
                begin
                    if (!code_ok(bus_i.wdata[6:0]))
                        err = 1'b1;
                    else if (bus_i.background_debug_path && secured && bus_i.wdata[6:0] != FCS_CMD_BLANK
                        && bus_i.wdata[6:0] != FCS_CMD_MASS)
                        err = 1'b1;
                    else
                    begin
                        pend_nxt.cmd = bus_i.wdata[6:0];
                        seq_nxt = FCS_SEQ_CMDWR;
                    end
                end
                else if (ctrl_wr)
                    err = 1'b1;
            end
            FCS_SEQ_CMDWR:
            begin
                if (ctrl_wr && bus_i.addr == FCS_ADDR_STATUS && bus_i.wdata[FCS_ST_CBEF])
                    launch = 1'b1;
                else if (arr_wr || ctrl_wr || ctrl_rd)
                    err = 1'b1;
            end
            FCS_SEQ_QUEUED:
            begin
                if (arr_wr)
                    err = 1'b1;
            end
            default:
            begin
                seq_nxt = FCS_SEQ_IDLE;
            end
        endcase

        if (err && seq_r != FCS_SEQ_QUEUED)
            seq_nxt = FCS_SEQ_IDLE;

        if (launch)
        begin
            ccf_nxt = 1'b0;
            if ((pend_r.cmd == FCS_CMD_MASS && !protection_reg_r[FCS_PROT_DIS])
                || (pend_r.cmd != FCS_CMD_BLANK && pend_r.cmd != FCS_CMD_MASS
                && prot_hit(protection_reg_r, pend_r.addr)))
            begin
                refused = 1'b1;
                pviol_nxt = 1'b1;
                ccf_nxt = !running;
                seq_nxt = FCS_SEQ_IDLE;
            end
            else
                seq_nxt = FCS_SEQ_QUEUED;
        end

        // Execution engine
        burst_chain = nvm_o.prog && nvm_o.pump && (pend_r.cmd == FCS_CMD_BURST)
            && (pend_r.addr == next_addr)
            && (pend_r.addr[FCS_ROW_LSB-1:0] != FCS_ROW_START);
        if (running && fclk_tick && !done)
            cnt_nxt = cnt_r - FCS_CNT_ONE;
        if (done)
        begin
            nvm_nxt.prog = 1'b0;
            nvm_nxt.erase = 1'b0;
            nvm_nxt.mass = 1'b0;
            if (nvm_o.blank_chk)
                blank_nxt = nvm_blank_i;
            nvm_nxt.blank_chk = 1'b0;
            if (seq_r == FCS_SEQ_QUEUED && burst_chain)
                nvm_nxt.pump = 1'b1;
            else
                nvm_nxt.pump = 1'b0;
            if (seq_nxt != FCS_SEQ_QUEUED)
                ccf_nxt = 1'b1;
        end
        if (seq_r == FCS_SEQ_QUEUED && (!running || (done && burst_chain)))
        begin
            start_q = 1'b1;
            seq_nxt = FCS_SEQ_IDLE;
            nvm_nxt.addr = pend_r.addr;
            nvm_nxt.data = pend_r.data;
            nvm_nxt.prog = (pend_r.cmd == FCS_CMD_BYTE) || (pend_r.cmd == FCS_CMD_BURST);
            nvm_nxt.erase = (pend_r.cmd == FCS_CMD_PAGE) || (pend_r.cmd == FCS_CMD_MASS);
            nvm_nxt.mass = (pend_r.cmd == FCS_CMD_MASS);
            nvm_nxt.blank_chk = (pend_r.cmd == FCS_CMD_BLANK);
            nvm_nxt.pump = pend_r.cmd != FCS_CMD_BLANK;
            if (pend_r.cmd == FCS_CMD_BLANK)
                blank_nxt = 1'b0;
            cnt_nxt = (done && burst_chain) ? FCS_BURST_CYC : op_time(pend_r.cmd);
        end

        // Stop mode abandons program and erase, and anything queued behind it
        if (stop_i && (nvm_o.prog || nvm_o.erase))
        begin
            nvm_nxt.prog = 1'b0;
            nvm_nxt.erase = 1'b0;
            nvm_nxt.mass = 1'b0;
            nvm_nxt.pump = 1'b0;
            seq_nxt = FCS_SEQ_IDLE;
            err = 1'b1;
            ccf_nxt = 1'b1;
        end

        // A new error wins over a clear written in the same cycle
        accerr_nxt = accerr_r;
        if (ctrl_wr && bus_i.addr == FCS_ADDR_STATUS && bus_i.wdata[FCS_ST_ACCERR])
            accerr_nxt = 1'b0;
        if (err)
            accerr_nxt = 1'b1;

        // Read data
        unique case (bus_i.addr)
            FCS_ADDR_CLKDIV: rdata_nxt = clock_divider_r;
            FCS_ADDR_OPTION: rdata_nxt = option_r;
            FCS_ADDR_PROT: rdata_nxt = protection_reg_r;
            FCS_ADDR_STATUS: rdata_nxt = {seq_r != FCS_SEQ_QUEUED, ccf_r, pviol_r,
                accerr_r, 1'b0, blank_r, 2'b00};
            FCS_ADDR_CMD: rdata_nxt = {1'b0, pend_r.cmd};
            default: rdata_nxt = FCS_ZERO8;
        endcase
        if (!bus_i.rd)
            rdata_nxt = FCS_ZERO8;

        // Vector fetch redirection; the reset vector stays where it is
        vec_nxt = vec_addr_i;
        if (!option_r[FCS_OPT_NORED] && !protection_reg_r[FCS_PROT_DIS]
            && lu >= FCS_FLASH_BASE
            && vec_addr_i >= FCS_VEC_LO && vec_addr_i <= FCS_VEC_HI)
        begin
            vec_nxt = {lu[15:FCS_ROW_LSB], vec_addr_i[FCS_ROW_LSB-1:0]};
        end
    end

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    always_ff @(posedge mclk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            seq_r <= FCS_SEQ_IDLE;
            pend_r <= '0;
            nvm_o <= '0;
            cnt_r <= '0;
            clock_divider_r <= FCS_ZERO8;
            protection_reg_r <= FCS_ZERO8;
            option_r <= FCS_ZERO8;
            nv_loaded_r <= 1'b0;
            ccf_r <= 1'b1;
            accerr_r <= 1'b0;
            pviol_r <= 1'b0;
            blank_r <= 1'b0;
            bus_rdata_o <= FCS_ZERO8;
            vec_addr_o <= '0;
        end
        else
        begin
            seq_r <= seq_nxt;
            pend_r <= pend_nxt;
            nvm_o <= nvm_nxt;
            cnt_r <= cnt_nxt;
            clock_divider_r <= clock_divider_nxt;
            protection_reg_r <= protection_reg_nxt;
            option_r <= option_nxt;
            nv_loaded_r <= nv_loaded_nxt;
            ccf_r <= ccf_nxt;
            accerr_r <= accerr_nxt;
            pviol_r <= pviol_nxt;
            blank_r <= blank_nxt;
            bus_rdata_o <= rdata_nxt;
            vec_addr_o <= vec_nxt;
        end
    end

endmodule // fcs_top

// ### design/fcs_pkg.sv
package fcs_pkg;

    // ----------------------------------------------------------------
    // Control register addresses and array geometry
    // ----------------------------------------------------------------
    localparam logic [15:0] FCS_ADDR_CLKDIV = 16'h1820;
    localparam logic [15:0] FCS_ADDR_OPTION = 16'h1821;
    localparam logic [15:0] FCS_ADDR_CONFIG = 16'h1823;
    localparam logic [15:0] FCS_ADDR_PROT = 16'h1824;
    localparam logic [15:0] FCS_ADDR_STATUS = 16'h1825;
    localparam logic [15:0] FCS_ADDR_CMD = 16'h1826;
    localparam logic [15:0] FCS_ADDR_NV_PROT = 16'hffbd;
    localparam logic [15:0] FCS_ADDR_NV_OPT = 16'hffbf;
    localparam logic [15:0] FCS_FLASH_BASE = 16'he000;
    localparam logic [15:0] FCS_VEC_LO = 16'hffc0;
    localparam logic [15:0] FCS_VEC_HI = 16'hfffd;
    localparam logic [5:0] FCS_ROW_START = 6'h00;
    localparam int FCS_ROW_LSB = 6;
    localparam int FCS_BOUND_LSB = 9;

    // ----------------------------------------------------------------
    // Field positions and values
    // ----------------------------------------------------------------
    localparam int FCS_ST_CBEF = 7;
    localparam int FCS_ST_CCF = 6;
    localparam int FCS_ST_PVIOL = 5;
    localparam int FCS_ST_ACCERR = 4;
    localparam int FCS_ST_BLANK = 2;
    localparam int FCS_DIV_LOADED = 7;
    localparam int FCS_DIV_PRE8 = 6;
    localparam int FCS_OPT_NORED = 6;
    localparam int FCS_PROT_DIS = 0;
    localparam logic [1:0] FCS_SEC_OPEN = 2'h2;
    localparam logic [2:0] FCS_PRE8_LAST = 3'h7;
    localparam logic [7:0] FCS_ZERO8 = 8'h00;

    // ----------------------------------------------------------------
    // Timing in flash clock cycles
    // ----------------------------------------------------------------
    localparam int FCS_CNT_W = 15;
    localparam logic [14:0] FCS_BYTE_CYC = 15'h0009;
    localparam logic [14:0] FCS_BURST_CYC = 15'h0004;
    localparam logic [14:0] FCS_BLANK_CYC = 15'h0010;
    localparam int FCS_PAGE_CYC = 32'h00000fa0;
    localparam int FCS_MASS_CYC = 32'h00004e20;
    localparam logic [14:0] FCS_CNT_ONE = 15'h0001;

    // ----------------------------------------------------------------
    // Types
    // ----------------------------------------------------------------
    typedef enum logic [6:0] {
        FCS_CMD_BLANK = 7'h05,
        FCS_CMD_BYTE = 7'h20,
        FCS_CMD_BURST = 7'h25,
        FCS_CMD_PAGE = 7'h40,
        FCS_CMD_MASS = 7'h41
    } fcs_cmd_t;

    typedef enum logic [1:0] {
        FCS_SEQ_IDLE = 2'h0,
        FCS_SEQ_LATCHED = 2'h1,
        FCS_SEQ_CMDWR = 2'h3,
        FCS_SEQ_QUEUED = 2'h2
    } fcs_seq_t;

    typedef struct packed {
        logic wr;
        logic rd;
        logic background_debug_path;
        logic [15:0] addr;
        logic [7:0] wdata;
    } fcs_bus_t;

    typedef struct packed {
        logic [6:0] cmd;
        logic [15:0] addr;
        logic [7:0] data;
    } fcs_pend_t;

    typedef struct packed {
        logic pump;
        logic prog;
        logic erase;
        logic mass;
        logic blank_chk;
        logic [15:0] addr;
        logic [7:0] data;
    } fcs_nvm_t;

endpackage

// ### design/fcs_fclk_div.sv
`timescale 1ns/1ps
module fcs_fclk_div
    import fcs_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic run_i,
    input wire logic pre8_i,
    input wire logic [5:0] div_i,
    output logic tick_o
);
    import fcs_pkg::*;

    logic [2:0] pre_r, pre_nxt;
    logic [5:0] cnt_r, cnt_nxt;
    logic tick_nxt;
    logic pre_done;

    // ----------------------------------------------------------------
    // Flash timing clock: bus clock / (8 if pre8) / (div + 1)
    // ----------------------------------------------------------------
    always_comb
    begin
        pre_nxt = pre_r;
        cnt_nxt = cnt_r;
        tick_nxt = 1'b0;
        pre_done = !pre8_i || (pre_r == FCS_PRE8_LAST);
        if (run_i)
        begin
            pre_nxt = pre_done ? 3'h0 : pre_r + 3'h1;
            if (pre_done)
            begin
                if (cnt_r == div_i)
                begin
                    cnt_nxt = 6'h00;
                    tick_nxt = 1'b1;
                end
                else
                begin
                    cnt_nxt = cnt_r + 6'h01;
                end
            end
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            pre_r <= 3'h0;
            cnt_r <= 6'h00;
            tick_o <= 1'b0;
        end
        else
        begin
            pre_r <= pre_nxt;
            cnt_r <= cnt_nxt;
            tick_o <= tick_nxt;
        end
    end

endmodule // fcs_fclk_div

// ### test/fcs_array_model.sv
`timescale 1ns/1ps
module fcs_array_model
    import fcs_pkg::*;
(
    input wire logic clk_i,
    input wire fcs_pkg::fcs_nvm_t nvm_i,
    output logic blank_o
);
    // ----------------
    // Array contents, reduced to a single written or erased flag
    // ----------------
    logic written_r = 1'b1;
    always_ff @(posedge clk_i)
    begin
        if (nvm_i.erase && nvm_i.mass)
            written_r <= 1'b0;
        else if (nvm_i.prog)
            written_r <= 1'b1;
    end
    assign blank_o = !written_r;
endmodule // fcs_array_model

// ### test/fcs_top_sva.sv
`timescale 1ns/1ps
module fcs_top_sva
    import fcs_pkg::*;
(
    input wire logic mclk_i,
    input wire logic arst_n_i,
    input wire fcs_pkg::fcs_bus_t bus_i,
    input wire logic [7:0] bus_rdata_o,
    input wire logic stop_i,
    input wire fcs_pkg::fcs_nvm_t nvm_o,
    input wire logic [15:0] vec_addr_i,
    input wire logic [15:0] vec_addr_o
);
    import fcs_pkg::*;
    // ----------------
    // Properties
    // ----------------
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!arst_n_i);
    sequence s_stop_hit;
        stop_i && (nvm_o.prog || nvm_o.erase);
    endsequence
    sequence s_halted;
        !nvm_o.prog && !nvm_o.erase;
    endsequence
    sequence s_abort;
        bus_i.wr && bus_i.addr >= FCS_FLASH_BASE
        ##2 bus_i.wr && bus_i.addr == FCS_ADDR_STATUS && bus_i.wdata == 8'h00
        ##2 bus_i.rd && bus_i.addr == FCS_ADDR_STATUS;
    endsequence
    chk_stop_abort: assert property (s_stop_hit |-> ##[1:3] s_halted)
        else $error("operation kept running in stop mode");
    chk_abort_error: assert property (s_abort |=> bus_rdata_o[FCS_ST_ACCERR])
        else $error("cancelled sequence left access error clear");
    chk_rdata_idle: assert property (!$past(bus_i.rd) |-> bus_rdata_o == 8'h00)
        else $error("read data without a read");
    chk_status_resv: assert property ($past(bus_i.rd) && $past(bus_i.addr) == FCS_ADDR_STATUS
        |-> bus_rdata_o[3] == 1'b0 && bus_rdata_o[1:0] == 2'h0)
        else $error("status reserved bits not zero");
    chk_pump_prog: assert property (nvm_o.prog |-> nvm_o.pump)
        else $error("program without high voltage");
    chk_op_onehot: assert property ($onehot0({nvm_o.prog, nvm_o.erase, nvm_o.blank_chk}))
        else $error("two array operations at once");
    chk_erase_hold: assert property (nvm_o.erase && $past(nvm_o.erase) |-> $stable(nvm_o.addr))
        else $error("erase address moved");
    chk_vec_keep: assert property ((vec_addr_i < FCS_VEC_LO || vec_addr_i > FCS_VEC_HI)
        |=> vec_addr_o == $past(vec_addr_i))
        else $error("non-interrupt vector redirected");
endmodule // fcs_top_sva

bind fcs_top fcs_top_sva u_sva (
    .mclk_i(mclk_i), .arst_n_i(arst_n_i), .bus_i(bus_i), .bus_rdata_o(bus_rdata_o),
    .stop_i(stop_i), .nvm_o(nvm_o), .vec_addr_i(vec_addr_i), .vec_addr_o(vec_addr_o));

// ### test/flash_command_sequencer_tb.sv
`timescale 1ns/1ps
module flash_command_sequencer_tb;
    import fcs_pkg::*;
    logic mclk_i = 1'b0;
    logic arst_n_i = 1'b0;
    fcs_bus_t bus_i = '0;
    logic [7:0] bus_rdata_o;
    logic stop_i = 1'b0;
    logic [7:0] nvp = 8'hff;
    logic [7:0] nvo = 8'hc2;
    logic nvm_blank_i;
    fcs_nvm_t nvm_o;
    logic [15:0] vec_addr_i = 16'h0000;
    logic [15:0] vec_addr_o;
    logic [7:0] rd;
    logic pump_q = 1'b0;
    int bad_count = 0;
    int total_checks = 0;
    int pump_falls = 0;
    int n;
    fcs_cmd_t codes[5] = '{FCS_CMD_BYTE, FCS_CMD_BURST, FCS_CMD_PAGE, FCS_CMD_MASS, FCS_CMD_BLANK};
    // ----------------
    // Design, array model, clock
    // ----------------
    // Short erase counts keep the run small; flash tick is 128 bus cycles
    fcs_top #(.PAGE_CYC(20), .MASS_CYC(40)) dut (.mclk_i(mclk_i), .arst_n_i(arst_n_i),
        .bus_i(bus_i), .bus_rdata_o(bus_rdata_o), .stop_i(stop_i),
        .nv_protection_setting_i(nvp), .nv_option_setting_i(nvo), .nvm_blank_i(nvm_blank_i),
        .nvm_o(nvm_o), .vec_addr_i(vec_addr_i), .vec_addr_o(vec_addr_o));
    fcs_array_model u_arr (.clk_i(mclk_i), .nvm_i(nvm_o), .blank_o(nvm_blank_i));
    initial
    begin
        forever #20 mclk_i = ~mclk_i;
    end
    always @(posedge mclk_i)
    begin
        if (pump_q && nvm_o.pump === 1'b0)
            pump_falls++;
        pump_q <= (nvm_o.pump === 1'b1);
    end
    // ----------------
    // Bus tasks and checks
    // ----------------
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            bad_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic summarize();
        $display("checks=%0d mismatches=%0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic wr(input logic [15:0] a, input logic [7:0] d, input logic dbg);
        bus_i <= '{wr: 1'b1, rd: 1'b0, background_debug_path: dbg, addr: a, wdata: d};
        @(posedge mclk_i);
        bus_i <= '0;
        @(posedge mclk_i);
    endtask
    task automatic rdr(input logic [15:0] a, output logic [7:0] d);
        bus_i <= '{wr: 1'b0, rd: 1'b1, background_debug_path: 1'b0, addr: a, wdata: 8'h00};
        @(posedge mclk_i);
        bus_i <= '0;
        #1 d = bus_rdata_o;
        @(posedge mclk_i);
    endtask
    task automatic st(input logic [7:0] m, input logic [7:0] e);
        rdr(FCS_ADDR_STATUS, rd);
        chk({8'h00, rd & m}, {8'h00, e});
    endtask
    task automatic launch(input logic [15:0] a, input logic [7:0] d, input fcs_cmd_t c);
        wr(a, d, 1'b0);
        wr(FCS_ADDR_CMD, {1'b0, c}, 1'b0);
        wr(FCS_ADDR_STATUS, 8'h80, 1'b0);
    endtask
    task automatic wait_done();
        int k;
        k = 0;
        rd = 8'h00;
        while (rd[FCS_ST_CCF] !== 1'b1 && k < 4000)
        begin
            rdr(FCS_ADDR_STATUS, rd);
            k++;
        end
        chk({15'h0, rd[FCS_ST_CCF]}, 16'h0001);
    endtask
    task automatic burst2(input logic [15:0] a, input int f);
        int p;
        realtime t;
        p = pump_falls;
        t = $realtime;
        launch(a, 8'h11, FCS_CMD_BURST);
        launch(a + 16'h0001, 8'h22, FCS_CMD_BURST);
        wait_done();
        chk(16'(pump_falls - p), 16'(f));
        // A same-row pair is near 13 ticks, a row crossing near 18
        chk({15'h0, (($realtime - t) < 1920.0 * 40.0) == (f == 1)}, 16'h0001);
    endtask
    task automatic vec_chk(input logic [15:0] a, input logic [15:0] e);
        vec_addr_i <= a;
        repeat (2) @(posedge mclk_i);
        #1 chk(vec_addr_o, e);
        @(posedge mclk_i);
    endtask
    task automatic do_reset();
        arst_n_i <= 1'b0;
        repeat (4) @(posedge mclk_i);
        arst_n_i <= 1'b1;
        repeat (5) @(posedge mclk_i);
    endtask
    // ----------------
    // Scenarios
    // ----------------
    initial
    begin
        do_reset();
        st(8'hff, 8'hc0);
        wr(FCS_FLASH_BASE, 8'h00, 1'b0);
        st(8'h10, 8'h10);
        wr(FCS_ADDR_STATUS, 8'h10, 1'b0);
        st(8'hff, 8'hc0);
        wr(FCS_ADDR_CLKDIV, 8'h4f, 1'b0);
        wr(FCS_ADDR_CLKDIV, 8'h00, 1'b0);
        rdr(FCS_ADDR_CLKDIV, rd);
        chk({8'h00, rd}, 16'h00cf);
        launch(16'he000, 8'h55, FCS_CMD_BYTE);
        while (nvm_o.prog !== 1'b1 && n < 300)
        begin
            @(posedge mclk_i);
            n++;
        end
        chk(nvm_o.addr, 16'he000);
        chk({8'h00, nvm_o.data}, 16'h0055);
        n = 0;
        while (nvm_o.prog === 1'b1 && n < 3000)
        begin
            @(posedge mclk_i);
            n++;
        end
        chk({15'h0, n >= 1000 && n <= 1300}, 16'h0001);
        wait_done();
        st(8'hd0, 8'hc0);
        burst2(16'he010, 1);
        burst2(16'he03f, 2);
        for (int k = 0; k < 6; k++)
        begin
            wr(16'he100, 8'h00, 1'b0);
            if (k >= 4)
                wr(FCS_ADDR_CMD, 8'h20, 1'b0);
            case (k)
                0: wr(16'he101, 8'h00, 1'b0);
                1: wr(FCS_ADDR_CMD, 8'h30, 1'b0);
                2: wr(FCS_ADDR_CONFIG, 8'h00, 1'b0);
                3: wr(FCS_ADDR_STATUS, 8'h00, 1'b0);
                4: wr(FCS_ADDR_CMD, 8'h20, 1'b0);
                default: rdr(FCS_ADDR_PROT, rd);
            endcase
            st(8'hd0, 8'hd0);
            launch(16'he200, 8'haa, FCS_CMD_BYTE);
            repeat (3) @(posedge mclk_i);
            chk({15'h0, nvm_o.prog | nvm_o.pump}, 16'h0000);
            wr(FCS_ADDR_STATUS, 8'h10, 1'b0);
        end
        foreach (codes[i])
        begin
            launch(16'he300, 8'h00, codes[i]);
            wait_done();
            st(8'hd0, 8'hc0);
        end
        chk({15'h0, rd[FCS_ST_BLANK]}, 16'h0001);
        launch(16'he400, 8'h00, FCS_CMD_PAGE);
        repeat (4) @(posedge mclk_i);
        stop_i <= 1'b1;
        repeat (4) @(posedge mclk_i);
        stop_i <= 1'b0;
        chk({15'h0, nvm_o.erase}, 16'h0000);
        st(8'h10, 8'h10);
        wr(FCS_ADDR_STATUS, 8'h10, 1'b0);
        nvp <= 8'hfc;
        nvo <= 8'h03;
        do_reset();
        wr(FCS_ADDR_CLKDIV, 8'h4f, 1'b0);
        vec_chk(16'hffe0, 16'hfde0);
        vec_chk(16'hfffe, 16'hfffe);
        wr(FCS_ADDR_PROT, 8'hff, 1'b0);
        rdr(FCS_ADDR_PROT, rd);
        chk({8'h00, rd}, 16'h00fc);
        launch(16'hfe10, 8'h12, FCS_CMD_BYTE);
        repeat (4) @(posedge mclk_i);
        chk({15'h0, nvm_o.prog}, 16'h0000);
        st(8'h30, 8'h20);
        wr(FCS_ADDR_STATUS, 8'h20, 1'b0);
        wr(16'he000, 8'h00, 1'b1);
        wr(FCS_ADDR_CMD, 8'h20, 1'b1);
        st(8'h10, 8'h10);
        wr(FCS_ADDR_STATUS, 8'h10, 1'b0);
        wr(FCS_ADDR_PROT, 8'hff, 1'b1);
        vec_chk(16'hffe0, 16'hffe0);
        summarize();
    end
    initial
    begin
        #2000000;
        bad_count++;
        summarize();
    end
endmodule // flash_command_sequencer_tb
